/* File: src/adc_host_defines.svh */
`ifndef ADC_HOST_DEFINES_SVH
`define ADC_HOST_DEFINES_SVH

// Register offsets
`define REG_CTRL          4'h0
`define REG_STATUS        4'h4
`define REG_DATA          4'h8
// Control fields
`define CTRL_START_BIT    0
`define CTRL_MODE_LSB     1
`define CTRL_MODE_MSB     3
`define MODE_COUNT        3'h5
`define MODE_RESET        3'h1
// Status fields
`define STAT_BUSY_BIT     0
`define STAT_DONE_BIT     1
`define STAT_TOUT_BIT     2
`define STAT_FAST_OK_BIT  3
`define STAT_SLOW_OK_BIT  4
// Timing
`define SYS_CLK_MHZ       25
`define RESULT_BITS       16
`define SCK_HALF_CYC      4
`define SCK_MIN_FAST_HZ   70000000
`define SCK_MIN_SLOW_HZ   22000000
`define T_CONV_MIN_NS     300
`define T_CONV_MAX_NS     400
`define T_GAP_AFTER_NS    200
`define T_GAP_BEFORE_NS   100
`define CONV_MIN_CYC      ((`T_CONV_MIN_NS * `SYS_CLK_MHZ) / 1000)
`define CONV_MAX_CYC      ((`T_CONV_MAX_NS * `SYS_CLK_MHZ + 999) / 1000)
`define QUIET1_CYC        ((`T_GAP_AFTER_NS * `SYS_CLK_MHZ + 999) / 1000)
`define QUIET2_CYC        ((`T_GAP_BEFORE_NS * `SYS_CLK_MHZ + 999) / 1000)
`define START_PULSE_CYC   1
`define BUSY_TIMEOUT_CYC  64
`define COUNT_MAX         16'hFFFF
`endif

/* File: src/adc_host_pkg.sv */
package adc_host_pkg;
  typedef enum logic [2:0] {
    MODE_3W_TURBO,
    MODE_3W_PLAIN,
    MODE_3W_BUSY,
    MODE_4W_TURBO,
    MODE_4W_PLAIN
  } mode_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_SHIFT,
    ST_END
  } state_e;

  typedef struct packed {
    logic convert_start;
    logic serial_in_select;
    logic sck;
  } link_out_s;
endpackage

/* File: src/adc_select_host.sv */
`timescale 1ns/1ns
`include "adc_host_defines.svh"
module adc_select_host #(
  parameter int unsigned BITS      = `RESULT_BITS,
  parameter int unsigned HALF      = `SCK_HALF_CYC,
  parameter int unsigned CONV_MIN  = `CONV_MIN_CYC,
  parameter int unsigned CONV_MAX  = `CONV_MAX_CYC,
  parameter int unsigned QUIET1    = `QUIET1_CYC,
  parameter int unsigned QUIET2    = `QUIET2_CYC,
  parameter int unsigned PULSE     = `START_PULSE_CYC,
  parameter int unsigned BUSY_WAIT = `BUSY_TIMEOUT_CYC
) (
  input  wire logic                i_clk_sys,
  input  wire logic                i_sys_rst,
  input  wire logic [3:0]          i_addr,
  input  wire logic [31:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic [31:0]              o_rdata,
  input  wire logic                i_serial_out,
  output adc_host_pkg::link_out_s  o_link
);
  import adc_host_pkg::*;

  localparam logic [15:0] CMIN = 16'(CONV_MIN);
  localparam logic [15:0] CMAX = 16'(CONV_MAX);
  localparam logic [15:0] Q1 = 16'(QUIET1);
  localparam logic [15:0] Q2 = 16'(QUIET2);
  localparam logic [15:0] PLAST = 16'(PULSE - 1);
  localparam logic [15:0] TOUT = 16'(CONV_MAX + BUSY_WAIT);
  localparam int unsigned SCK_HZ = (`SYS_CLK_MHZ * 1000000) / (2 * HALF);
  localparam logic FAST_OK = (SCK_HZ >= `SCK_MIN_FAST_HZ);
  localparam logic SLOW_OK = (SCK_HZ >= `SCK_MIN_SLOW_HZ);

  if (HALF < 3 || BITS < 1 || BITS > 32 || PULSE < 1 || PULSE >= CONV_MIN || CONV_MIN > CONV_MAX
      || QUIET1 < 1 || QUIET2 < 1 || CONV_MAX + BUSY_WAIT > 65000)
  begin : g_bad_param
    $error("adc_select_host: parameter set cannot be served");
  end

  function automatic logic [31:0] low_mask(input int unsigned n);
    low_mask = (n >= 32) ? 32'hFFFFFFFF : ((32'h1 << n) - 32'h1);
  endfunction

  state_e      state;
  state_e      next_state;
  mode_e       mode;
  mode_e       next_mode;
  link_out_s   next_link;
  logic [31:0] next_rdata;
  logic        pend;
  logic        next_pend;
  logic        done;
  logic        next_done;
  logic        err;
  logic        next_err;
  logic [31:0] result;
  logic [31:0] next_result;
  logic [31:0] shreg;
  logic [31:0] next_shreg;
  logic [5:0]  edges;
  logic [5:0]  next_edges;
  logic [15:0] tmr;
  logic [15:0] next_tmr;
  logic [15:0] gap;
  logic [15:0] next_gap;
  logic        sout_meta;
  logic        sout_sync;
  logic        tick;
  logic        run;
  logic        busy;
  logic        fourw;
  logic        skip;
  logic        go_read;
  logic [5:0]  total;

  // Serial output pin synchroniser
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      sout_meta <= 1'b1;
      sout_sync <= 1'b1;
    end
    else
    begin
      sout_meta <= i_serial_out;
      sout_sync <= sout_meta;
    end
  end

  assign run = (state == ST_SHIFT);

  sck_divider #(
    .HALF (HALF)
  ) u_div (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_run     (run),
    .o_tick    (tick)
  );

  always_comb
  begin
    next_state = state;
    next_mode = mode;
    next_link = o_link;
    next_pend = pend;
    next_done = done;
    next_err = err;
    next_result = result;
    next_shreg = shreg;
    next_edges = edges;
    next_rdata = 32'h0;
    next_tmr = (tmr == `COUNT_MAX) ? tmr : tmr + 16'h0001;
    next_gap = (gap == `COUNT_MAX) ? gap : gap + 16'h0001;
    busy = pend || (state != ST_IDLE);
    fourw = (mode == MODE_4W_TURBO) || (mode == MODE_4W_PLAIN);
    skip = (mode == MODE_3W_BUSY);
    total = 6'(BITS) + {5'h0, skip};
    go_read = 1'b0;
    // Register writes; control is refused while a transfer is pending or running
    if (i_wr && i_addr == `REG_CTRL && !busy)
    begin
      if (i_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] < `MODE_COUNT)
        next_mode = mode_e'(i_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
      next_pend = i_wdata[`CTRL_START_BIT];
    end
    if (i_wr && i_addr == `REG_STATUS)
    begin
      next_done = done & ~i_wdata[`STAT_DONE_BIT];
      next_err = err & ~i_wdata[`STAT_TOUT_BIT];
    end
    if (i_rd)
    begin
      case (i_addr)
        `REG_CTRL:   next_rdata = {28'h0, mode, 1'b0};
        `REG_STATUS: next_rdata = {27'h0, SLOW_OK, FAST_OK, err, done, busy};
        `REG_DATA:   next_rdata = result;
        default:     next_rdata = 32'h0;
      endcase
    end
    // Link sequencer; hardware sets below win over software clears above
    case (state)
      ST_IDLE:
      begin
        next_tmr = 16'h0;
        next_edges = 6'h0;
        if (pend && gap >= Q2)
        begin
          next_pend = 1'b0;
          next_link.convert_start = 1'b1;
          next_link.serial_in_select = 1'b1;
          next_state = ST_CONV;
        end
      end
      ST_CONV:
      begin
        case (mode)
          MODE_3W_TURBO, MODE_4W_TURBO: go_read = (tmr >= Q1);
          MODE_3W_BUSY:
          begin
            if (tmr == PLAST)
              next_link.convert_start = 1'b0;
            if (!o_link.convert_start && tmr >= CMIN && !sout_sync)
              go_read = 1'b1;
            else if (tmr >= TOUT)
            begin
              next_err = 1'b1;
              next_state = ST_END;
            end
          end
          default: go_read = (tmr >= CMAX);
        endcase
        if (go_read)
        begin
          if (fourw)
            next_link.serial_in_select = 1'b0;
          else
            next_link.convert_start = 1'b0;
          next_link.sck = 1'b0;
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT:
      begin
        if (tick)
        begin
          if (!o_link.sck)
            next_link.sck = 1'b1;
          else
          begin
            if (edges >= {5'h0, skip})
              next_shreg = {shreg[30:0], sout_sync};
            next_link.sck = 1'b0;
            next_edges = edges + 6'h01;
            if (edges + 6'h01 == total)
            begin
              next_gap = 16'h0;
              next_state = ST_END;
            end
          end
        end
      end
      ST_END:
      begin
        if (fourw)
        begin
          next_link.serial_in_select = 1'b1;
          if (tmr >= CMAX)
            next_link.convert_start = 1'b0;
        end
        if (tmr >= CMAX && gap >= Q2 && !(fourw && o_link.convert_start))
        begin
          if (edges == total)
          begin
            next_result = shreg & low_mask(BITS);
            next_done = 1'b1;
          end
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      state <= ST_IDLE;
      mode <= mode_e'(`MODE_RESET);
      o_link <= '{convert_start: 1'b0, serial_in_select: 1'b1, sck: 1'b0};
      o_rdata <= 32'h0;
      pend <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      result <= 32'h0;
      shreg <= 32'h0;
      edges <= 6'h0;
      tmr <= 16'h0;
      gap <= `COUNT_MAX;
    end
    else
    begin
      state <= next_state;
      mode <= next_mode;
      o_link <= next_link;
      o_rdata <= next_rdata;
      pend <= next_pend;
      done <= next_done;
      err <= next_err;
      result <= next_result;
      shreg <= next_shreg;
      edges <= next_edges;
      tmr <= next_tmr;
      gap <= next_gap;
    end
  end

  // Helper counters: cycles since convert rise and since serial clock fall
  logic [15:0] h_rise;
  logic [15:0] h_fall;
  logic [15:0] next_h_rise;
  logic [15:0] next_h_fall;

  always_comb
  begin
    next_h_rise = (h_rise == `COUNT_MAX) ? h_rise : h_rise + 16'h0001;
    next_h_fall = (h_fall == `COUNT_MAX) ? h_fall : h_fall + 16'h0001;
    if (next_link.convert_start && !o_link.convert_start)
      next_h_rise = 16'h0;
    if (!next_link.sck && o_link.sck)
      next_h_fall = 16'h0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      h_rise <= `COUNT_MAX;
      h_fall <= `COUNT_MAX;
    end
    else
    begin
      h_rise <= next_h_rise;
      h_fall <= next_h_fall;
    end
  end

  sequence s_turbo3_read;
    mode == MODE_3W_TURBO && $fell(o_link.convert_start);
  endsequence

  sequence s_turbo4_read;
    mode == MODE_4W_TURBO && $fell(o_link.serial_in_select);
  endsequence

  sequence s_busy_start;
    mode == MODE_3W_BUSY && $rose(o_link.convert_start);
  endsequence

  a_turbo3_start_gap: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_turbo3_read |-> h_rise == 16'(QUIET1 + 1)) else $error("convert_start dropped early in 3-wire turbo");
  a_turbo4_sel_gap: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_turbo4_read |-> h_rise == 16'(QUIET1 + 1)) else $error("select dropped early in 4-wire turbo");
  a_quiet_before_start: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(o_link.convert_start) |-> h_fall > 16'(QUIET2)) else $error("convert rise too soon after clock fall");
  a_sck_idle_conv: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!fourw && state == ST_CONV) |-> !o_link.sck && $stable(o_link.sck)) else $error("serial clock active in conversion");
  a_busy_start_low: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_busy_start |=> !o_link.convert_start [*8]) else $error("convert_start not held low for start bit");
  a_busy_hold_low: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (mode == MODE_3W_BUSY && h_rise >= 16'(PULSE) && h_rise <= CMAX) |-> !o_link.convert_start)
    else $error("convert_start rose before maximum conversion time");
  a_plain3_start_high: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (mode == MODE_3W_PLAIN && h_rise <= CMAX) |-> o_link.convert_start) else $error("convert_start low in conversion");
  a_plain4_start_held: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (mode == MODE_4W_PLAIN && !o_link.serial_in_select) |-> o_link.convert_start)
    else $error("convert_start low during 4-wire readout");
  a_plain4_sel_high: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (mode == MODE_4W_PLAIN && h_rise <= CMAX) |-> o_link.serial_in_select) else $error("select low in conversion");
  a_edge_count: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (state == ST_END && $past(state) == ST_SHIFT) |-> edges == total && !o_link.sck)
    else $error("wrong number of serial clock falls");
endmodule

/* File: src/sck_divider.sv */
`timescale 1ns/1ns
module sck_divider #(
  parameter int unsigned HALF = 4
) (
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  input  wire logic i_run,
  output logic      o_tick
);
  localparam int unsigned W = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [W-1:0] LAST = W'(HALF - 1);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  if (HALF < 2)
  begin : g_bad_half
    $error("sck_divider: HALF must be at least 2");
  end

  // Half-period tick while running
  always_comb
  begin
    next_cnt = cnt;
    o_tick = 1'b0;
    if (!i_run)
      next_cnt = '0;
    else if (cnt == LAST)
    begin
      next_cnt = '0;
      o_tick = 1'b1;
    end
    else
      next_cnt = cnt + W'(1);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end
endmodule

/* File: testbench/adc_device_model.sv */
`timescale 1ns/1ns
module adc_device_model #(
  parameter int unsigned T_CONV_NS = 160,
  parameter int unsigned T_Q1_NS   = 80,
  parameter int unsigned T_Q2_NS   = 80
) (
  input  wire logic                     i_turbo,
  input  wire logic [15:0]              i_sample,
  input  wire adc_host_pkg::link_out_s  i_link,
  output logic                          o_serial_out,
  output logic [7:0]                    o_faults
);
  import adc_host_pkg::*;
  logic        converting;
  logic        drive;
  logic [15:0] completed;
  logic [15:0] shreg;
  logic [15:0] taking;
  logic [16:0] frame;
  int          falls;
  int          limit;
  time         t_rise;
  time         t_fall;

  initial
  begin
    converting = 1'b0;
    drive = 1'b0;
    completed = 16'h0000;
    shreg = 16'h0000;
    taking = 16'h0000;
    frame = 17'h00000;
    falls = 0;
    limit = 16;
    o_faults = 8'h00;
    t_rise = 0;
    t_fall = 0;
  end

  // Load a frame for readout, previous result allowed while converting in turbo
  task start_read;
    begin
      if (i_turbo && ($time - t_rise) < T_Q1_NS) o_faults = o_faults + 8'h01;
      if (!converting || i_turbo)
      begin
        frame = {shreg, 1'b1};
        falls = 0;
        limit = 16;
        drive = 1'b1;
      end
    end
  endtask

  // Convert rise: float, choose select mode, run conversion to the end
  always @(posedge i_link.convert_start)
  begin
    drive = 1'b0;
    if (i_link.serial_in_select)
    begin
      if (t_fall > 0 && ($time - t_fall) < T_Q2_NS) o_faults = o_faults + 8'h01;
      converting = 1'b1;
      taking = i_sample;
      t_rise = $time;
      if (i_turbo) shreg = completed;
      #(T_CONV_NS);
      converting = 1'b0;
      completed = taking;
      if (!i_turbo)
      begin
        shreg = taking;
        if (!i_link.convert_start || !i_link.serial_in_select)
        begin
          frame = {1'b0, shreg};
          falls = 0;
          limit = 17;
          drive = 1'b1;
        end
      end
    end
  end

  always @(negedge i_link.convert_start)
    if (i_link.serial_in_select) start_read();

  always @(negedge i_link.serial_in_select)
    if (i_link.convert_start) start_read();

  always @(posedge i_link.serial_in_select)
    drive = 1'b0;

  always @(posedge i_link.sck)
    if (converting && !i_turbo) o_faults = o_faults + 8'h01;

  // Shift on clock falls, float after the last bit
  always @(negedge i_link.sck)
  begin
    t_fall = $time;
    if (drive)
    begin
      frame = frame << 1;
      falls = falls + 1;
      if (falls == limit) drive = 1'b0;
    end
  end

  // Pull-up when floated
  assign o_serial_out = (!i_link.convert_start && !i_link.serial_in_select) ? 1'b0 :
                        (drive ? frame[16] : 1'b1);
endmodule

/* File: testbench/tb_adc_select_host.sv */
`timescale 1ns/1ns
`include "adc_host_defines.svh"
module tb_adc_select_host;
  import adc_host_pkg::*;
  logic        i_clk_sys;
  logic        i_sys_rst;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        serial_line;
  link_out_s   o_link;
  logic        turbo;
  logic [15:0] sample;
  logic [15:0] completed;
  logic [7:0]  faults;
  logic [31:0] got;
  int          fail_count;
  int          checks;
  int          sck_falls;
  int          n;

  adc_select_host #(.HALF(3), .CONV_MIN(3), .CONV_MAX(5), .QUIET1(2), .QUIET2(2)) adc_select_host_i (
    .i_clk_sys    (i_clk_sys),
    .i_sys_rst    (i_sys_rst),
    .i_addr       (i_addr),
    .i_wdata      (i_wdata),
    .i_wr         (i_wr),
    .i_rd         (i_rd),
    .o_rdata      (o_rdata),
    .i_serial_out (serial_line),
    .o_link       (o_link)
  );

  adc_device_model adc_device_model_i (
    .i_turbo      (turbo),
    .i_sample     (sample),
    .i_link       (o_link),
    .o_serial_out (serial_line),
    .o_faults     (faults)
  );

  initial
  begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  always @(negedge o_link.sck)
    sck_falls = sck_falls + 1;

  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task check_word(input logic [31:0] g, input logic [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e)
      begin
        $display("Error at %0t: got %h expected %h", $time, g, e);
        fail_count = fail_count + 1;
      end
    end
  endtask

  task reg_write(input logic [3:0] a, input logic [31:0] d);
    begin
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
    end
  endtask

  task reg_read(input logic [3:0] a, output logic [31:0] d);
    begin
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
    end
  endtask

  task automatic run_conv(input mode_e mode, input logic [15:0] smp);
    logic [31:0] r;
    logic        tb;
    int          k;
    begin
      tb = (mode == MODE_3W_TURBO) || (mode == MODE_4W_TURBO);
      turbo <= tb;
      sample <= smp;
      sck_falls = 0;
      reg_write(`REG_CTRL, {28'h0, mode, 1'b1});
      // Control write while busy must be ignored
      reg_write(`REG_CTRL, 32'h1);
      r = 32'h0;
      k = 0;
      while (r[1] !== 1'b1 && k < 200)
      begin
        reg_read(`REG_STATUS, r);
        k = k + 1;
      end
      check_word(r, 32'h2);
      reg_read(`REG_CTRL, r);
      check_word({29'h0, r[3:1]}, {29'h0, mode});
      check_word(sck_falls, (mode == MODE_3W_BUSY) ? 32'd17 : 32'd16);
      check_word({29'h0, o_link}, 32'h2);
      reg_read(`REG_DATA, r);
      check_word(r, {16'h0, tb ? completed : smp});
      completed = smp;
      reg_write(`REG_STATUS, 32'h2);
      reg_read(`REG_STATUS, r);
      check_word(r, 32'h0);
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    fail_count = fail_count + 1;
    report_and_stop();
  end

  initial
  begin
    i_sys_rst = 1'b1;
    i_addr = 4'h0;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    turbo = 1'b0;
    sample = 16'h0000;
    completed = 16'h0000;
    fail_count = 0;
    checks = 0;
    sck_falls = 0;
    repeat (3) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    #1;
    check_word({29'h0, o_link}, 32'h2);
    reg_read(`REG_STATUS, got);
    check_word(got, 32'h0);
    reg_read(`REG_CTRL, got);
    check_word({29'h0, got[3:1]}, 32'h1);
    reg_read(4'hC, got);
    check_word(got, 32'h0);
    reg_write(`REG_CTRL, 32'hA);
    reg_read(`REG_CTRL, got);
    check_word({29'h0, got[3:1]}, 32'h1);
    run_conv(MODE_3W_PLAIN, 16'h7FFE);
    run_conv(MODE_3W_TURBO, 16'hA5C3);
    run_conv(MODE_3W_BUSY, 16'h0001);
    run_conv(MODE_4W_TURBO, 16'hFFFF);
    run_conv(MODE_4W_PLAIN, 16'h8001);
    check_word({24'h0, faults}, 32'h0);
    // Device set for turbo while host waits for a start bit: host must time out
    turbo <= 1'b1;
    sck_falls = 0;
    reg_write(`REG_CTRL, {28'h0, MODE_3W_BUSY, 1'b1});
    got = 32'h0;
    n = 0;
    while (got[2] !== 1'b1 && n < 200)
    begin
      reg_read(`REG_STATUS, got);
      n = n + 1;
    end
    check_word({31'h0, got[2]}, 32'h1);
    check_word(sck_falls, 32'd0);
    reg_read(`REG_DATA, got);
    check_word(got, 32'h8001);
    reg_write(`REG_STATUS, 32'h4);
    reg_read(`REG_STATUS, got);
    check_word({31'h0, got[2]}, 32'h0);
    report_and_stop();
  end
endmodule
